// ### hw/lps_top.sv
// laser pulse sequencer: marking, thermalization and first-pulse suppression
module lps_top
  import lps_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic auto_mode_i,
  input wire logic begin_engrave_in_i,
  input wire logic halt_engrave_in_i,
  input wire logic [7:0] mark_level_i,
  input wire logic [7:0] therm_level_i,
  input wire logic [15:0] pulse_period_i,
  output logic pulse_gate_mod_o,
  output logic emission_o,
  output logic [7:0] level_o,
  output logic [7:0] diode_current_o,
  output logic trace_o,
  output logic marking_o
);
  typedef struct packed {
    logic [1:0] beg_sync;
    logic [1:0] halt_sync;
    logic [1:0] auto_sync;
    lps_phase_t phase;
    logic [15:0] cnt;
    logic [15:0] period;
    logic gate;
    logic emis;
    logic [7:0] lvl;
    logic [7:0] cur;
  } lps_st_t;
  lps_st_t st_reg;
  lps_st_t st_next;
  logic [7:0] slew_target;
  logic [7:0] slew_cur;
  logic [15:0] per_clamped;

  // clamp requested period into the supported repetition band
  always_comb begin
    if (pulse_period_i < 16'(PERIOD_MIN_CYC)) begin
      per_clamped = 16'(PERIOD_MIN_CYC);
    end else if (pulse_period_i > 16'(PERIOD_MAX_CYC)) begin
      per_clamped = 16'(PERIOD_MAX_CYC);
    end else begin
      per_clamped = pulse_period_i;
    end
  end

  // diode target is zero whenever emission is off
  assign slew_target = st_reg.emis ? st_reg.lvl : 8'h00;

  lps_slew u_slew (
    .clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i),
    .target_i(slew_target),
    .current_o(slew_cur)
  );

  // phase sequencer; begin, halt and mode inputs read only after both sync stages, level and period inputs read directly
  always_comb begin
    st_next = st_reg;
    st_next.beg_sync = {st_reg.beg_sync[0], begin_engrave_in_i};
    st_next.halt_sync = {st_reg.halt_sync[0], halt_engrave_in_i};
    st_next.auto_sync = {st_reg.auto_sync[0], auto_mode_i};
    st_next.cur = slew_cur;
    st_next.cnt = st_reg.cnt + 16'h0001;
    unique case (st_reg.phase)
      LPS_IDLE: begin
        st_next.gate = 1'b0;
        st_next.emis = 1'b0;
        st_next.lvl = 8'h00;
        if (!st_reg.auto_sync[1]) begin
          st_next.phase = LPS_TRACE;
        end else if (st_reg.beg_sync[1]) begin
          // crystal may be charged from an earlier run; suppress first
          st_next.phase = LPS_SUPPR;
          st_next.cnt = 16'h0000;
        end
      end
      LPS_MARK: begin
        st_next.emis = 1'b1;
        st_next.lvl = mark_level_i;
        if (st_reg.halt_sync[1] || !st_reg.auto_sync[1]) begin
          st_next.phase = LPS_THERM;
          st_next.gate = 1'b0;
          st_next.cnt = 16'h0000;
        end else begin
          // short gate opening at the start of every period
          if (st_reg.cnt >= st_reg.period - 16'h0001) begin
            st_next.cnt = 16'h0000;
            st_next.period = per_clamped;
          end
          st_next.gate = (st_next.cnt < 16'(SHOT_CYC));
        end
      end
      LPS_THERM: begin
        st_next.gate = 1'b0;
        st_next.emis = 1'b1;
        st_next.lvl = therm_level_i;
        if (!st_reg.auto_sync[1]) begin
          st_next.phase = LPS_TRACE;
          st_next.emis = 1'b0;
          st_next.lvl = 8'h00;
        end else if (st_reg.beg_sync[1] && !st_reg.halt_sync[1]) begin
          // cut pumping on this edge so the whole hold is dark, not one cycle short
          st_next.phase = LPS_SUPPR;
          st_next.cnt = 16'h0000;
          st_next.emis = 1'b0;
        end
      end
      LPS_SUPPR: begin
        st_next.gate = 1'b0;
        st_next.emis = 1'b0;
        if (!st_reg.auto_sync[1]) begin
          st_next.phase = LPS_TRACE;
        end else if (st_reg.cnt >= 16'(SUPPR_CYC - 1)) begin
          st_next.phase = LPS_MARK;
          st_next.period = per_clamped;
          st_next.cnt = 16'h0000;
          st_next.emis = 1'b1;
          st_next.gate = 1'b1;
          st_next.lvl = mark_level_i;
        end
      end
      LPS_TRACE: begin
        // outline preview only: no emission, begin and halt inputs ignored
        st_next.gate = 1'b0;
        st_next.emis = 1'b0;
        st_next.lvl = 8'h00;
        if (st_reg.auto_sync[1]) begin
          st_next.phase = LPS_IDLE;
        end
      end
      default: begin
        st_next.phase = LPS_IDLE;
        st_next.gate = 1'b0;
        st_next.emis = 1'b0;
      end
    endcase
  end

  // mode sync starts as automatic, so a release shows no false trace phase
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_reg <= '{beg_sync: 2'b00, halt_sync: 2'b00, auto_sync: 2'b11, phase: LPS_IDLE,
                  cnt: 16'h0000, period: PERIOD_RST, gate: 1'b0, emis: 1'b0,
                  lvl: 8'h00, cur: 8'h00};
    end else begin
      st_reg <= st_next;
    end
  end

  assign pulse_gate_mod_o = st_reg.gate;
  assign emission_o = st_reg.emis;
  assign level_o = st_reg.lvl;
  assign diode_current_o = st_reg.cur;
  // one-hot phase bits, so these come straight from the phase flops
  assign trace_o = st_reg.phase[4];
  assign marking_o = st_reg.phase[1];

  // helper: cycles spent with emission off before marking
  logic [15:0] off_cnt;
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      off_cnt <= 16'h0000;
    end else if (st_reg.emis) begin
      off_cnt <= 16'h0000;
    end else if (off_cnt != 16'hffff) begin
      off_cnt <= off_cnt + 16'h0001;
    end
  end

  suppr_hold_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (st_reg.phase == LPS_SUPPR && st_next.phase == LPS_MARK) |-> off_cnt >= 16'(SUPPR_CYC - 1))
    else $error("marking started before suppression hold elapsed");
  therm_to_mark_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (st_reg.phase == LPS_THERM) |=> st_reg.phase != LPS_MARK)
    else $error("marking entered straight from thermalization");
  therm_out_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    $past(st_reg.phase == LPS_THERM) && st_reg.phase == LPS_THERM |-> emission_o && !pulse_gate_mod_o)
    else $error("thermalization outputs wrong");
  emis_zero_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    !emission_o [*3] |=> diode_current_o <= $past(diode_current_o))
    else $error("diode current rose with emission off");
  halt_ends_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (st_reg.phase == LPS_MARK && st_reg.halt_sync[1]) |=> st_reg.phase == LPS_THERM && !pulse_gate_mod_o)
    else $error("halt did not end marking");
  manual_quiet_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    trace_o |-> !emission_o && !pulse_gate_mod_o)
    else $error("emission in manual mode");
  period_band_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    marking_o |-> st_reg.period >= 16'(PERIOD_MIN_CYC) && st_reg.period <= 16'(PERIOD_MAX_CYC))
    else $error("pulse period out of band");
  begin_auto_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (st_reg.phase == LPS_IDLE && st_reg.auto_sync[1] && st_reg.beg_sync[1]) |=> st_reg.phase == LPS_SUPPR)
    else $error("begin input ignored in automatic mode");
  mark_level_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    $past(marking_o) && marking_o |-> level_o == $past(mark_level_i))
    else $error("marking level not followed");
  suppr_dark_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (st_reg.phase == LPS_SUPPR) |-> !emission_o && !pulse_gate_mod_o)
    else $error("emission or gate active during suppression");
  therm_level_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    $past(st_reg.phase == LPS_THERM) && st_reg.phase == LPS_THERM |-> level_o == $past(therm_level_i))
    else $error("thermalization level not followed");
  halt_wins_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (st_reg.phase == LPS_THERM && st_reg.halt_sync[1]) |=> st_reg.phase != LPS_SUPPR)
    else $error("begin taken while halt still high");
  gate_mark_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    pulse_gate_mod_o |-> marking_o)
    else $error("gate open outside marking");
endmodule

// ### hw/lps_pkg.sv
// package for the laser pulse sequencer: timing, levels and phase codes
package lps_pkg;
  localparam int unsigned CLK_HZ = 50_000_000;
  // pulse repetition limits
  localparam int unsigned FREQ_MIN_HZ = 20_000;
  localparam int unsigned FREQ_MAX_HZ = 100_000;
  localparam int unsigned PERIOD_MAX_CYC = CLK_HZ / FREQ_MIN_HZ;
  localparam int unsigned PERIOD_MIN_CYC = CLK_HZ / FREQ_MAX_HZ;
  // gate opening (shot) time per pulse, in ns
  localparam int unsigned SHOT_NS = 400;
  localparam int unsigned SHOT_CYC = (SHOT_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  // suppression hold, least time, in us
  localparam int unsigned SUPPR_US = 450;
  localparam int unsigned SUPPR_CYC = SUPPR_US * (CLK_HZ / 1_000_000);
  // diode slew: full scale in about 150 us
  localparam int unsigned SLEW_US = 150;
  localparam int unsigned SLEW_CYC = SLEW_US * (CLK_HZ / 1_000_000);
  localparam int unsigned LVL_W = 8;
  localparam logic [7:0] LVL_FULL = 8'hff;
  localparam int unsigned STEP_CYC = SLEW_CYC / 255;
  // thermalization level, about 90 percent of full scale
  localparam logic [7:0] THERM_LVL_RST = 8'he6;
  localparam logic [15:0] PERIOD_RST = 16'h09c4;
  typedef enum logic [4:0] {
    LPS_IDLE   = 5'b00001,
    LPS_MARK   = 5'b00010,
    LPS_THERM  = 5'b00100,
    LPS_SUPPR  = 5'b01000,
    LPS_TRACE  = 5'b10000
  } lps_phase_t;
endpackage

// ### hw/lps_slew.sv
// slew limiter: moves diode current one step per interval toward its target
module lps_slew
  import lps_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic [7:0] target_i,
  output logic [7:0] current_o
);
  typedef struct packed {
    logic [7:0] cur;
    logic [15:0] tick;
  } lps_slew_st_t;
  lps_slew_st_t st_reg;
  lps_slew_st_t st_next;

  // step only on tick, so full scale takes about the slew time
  always_comb begin
    st_next = st_reg;
    if (st_reg.tick >= 16'(STEP_CYC - 1)) begin
      st_next.tick = 16'h0000;
      if (target_i > st_reg.cur) begin
        st_next.cur = st_reg.cur + 8'h01;
      end else if (target_i < st_reg.cur) begin
        st_next.cur = st_reg.cur - 8'h01;
      end
    end else begin
      st_next.tick = st_reg.tick + 16'h0001;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  assign current_o = st_reg.cur;

  slew_step_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (st_reg.cur != $past(st_reg.cur)) |-> $past(st_reg.tick) == 16'(STEP_CYC - 1))
    else $error("diode current moved off its step tick");
endmodule

// ### verification/lps_ctrl_model.sv
// machine controller model: drives begin and halt levels as the bench asks
module lps_ctrl_model (
  input wire logic clk_sys_i,
  input wire logic req_begin_i,
  input wire logic req_halt_i,
  output logic begin_engrave_in_o,
  output logic halt_engrave_in_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // levels move just after the edge, held until the bench drops them
  initial begin
    begin_engrave_in_o = 1'b0;
    halt_engrave_in_o = 1'b0;
  end
  // requests are taken at the edge and shown a little later, so no race with the bench
  always @(posedge clk_sys_i) begin
    begin_engrave_in_o <= #1 req_begin_i;
    halt_engrave_in_o <= #1 req_halt_i;
  end
endmodule

// ### verification/laser_pulse_sequencer_tb_top.sv
// self-checking bench for the laser pulse sequencer
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin failures++; \
  $display("Error %s expected %0h seen %0h", nm, ex, got); end end
module laser_pulse_sequencer_tb_top;
  import lps_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic auto_mode_i = 1'b1;
  logic req_begin = 1'b0;
  logic req_halt = 1'b0;
  logic begin_w, halt_w, gate, emis, trace, mark;
  logic [7:0] mark_lvl = 8'h80;
  logic [7:0] therm_lvl = 8'h60;
  logic [15:0] period = 16'h09c4;
  logic [7:0] lvl, diode;
  int failures = 0;
  int num_checks = 0;
  int seed = 77711;
  lps_ctrl_model u_lps_ctrl_model (.clk_sys_i(clk_sys_i), .req_begin_i(req_begin), .req_halt_i(req_halt),
    .begin_engrave_in_o(begin_w), .halt_engrave_in_o(halt_w));
  lps_top u_lps_top (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .auto_mode_i(auto_mode_i),
    .begin_engrave_in_i(begin_w), .halt_engrave_in_i(halt_w), .mark_level_i(mark_lvl),
    .therm_level_i(therm_lvl), .pulse_period_i(period), .pulse_gate_mod_o(gate), .emission_o(emis),
    .level_o(lvl), .diode_current_o(diode), .trace_o(trace), .marking_o(mark));
  initial begin
    forever #10 clk_sys_i = ~clk_sys_i;
  end
  // expected repetition period after the design's clamp
  function automatic int exp_period(input int p);
    return (p < 500) ? 500 : ((p > 2500) ? 2500 : p);
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  task automatic wrap_up();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // begin from idle or thermalization, then measure the pulse train
  task automatic run_mark();
    int i, ez, gz, hw, lw;
    ez = 0;
    gz = 0;
    hw = 0;
    lw = 0;
    req_begin = 1'b1;
    for (i = 0; i < 30000 && mark !== 1'b1; i++) begin
      if (gate !== 1'b0) gz++;
      if (emis === 1'b0) ez++;
      tick(1);
    end
    req_begin = 1'b0;
    `CHK("gate_in_suppr", 0, gz)
    `CHK("suppr_long", 1'b1, ez >= SUPPR_CYC)
    `CHK("diode_cut", 8'h00, diode)
    for (i = 0; i < 100 && gate === 1'b1; i++) tick(1);
    for (i = 0; i < 3000 && gate !== 1'b1; i++) tick(1);
    for (i = 0; i < 3000 && gate === 1'b1; i++) begin hw++; tick(1); end
    for (i = 0; i < 3000 && gate !== 1'b1; i++) begin lw++; tick(1); end
    `CHK("shot_width", SHOT_CYC, hw)
    `CHK("rep_period", exp_period(period), hw + lw)
    `CHK("emission_mark", 1'b1, emis)
    `CHK("level_mark", mark_lvl, lvl)
    `CHK("slew_partial", 1'b1, diode < mark_lvl)
    tick(255 * 29 + 200);
    `CHK("diode_level", mark_lvl, diode)
  endtask
  task automatic halt_to_therm();
    int i, gz;
    gz = 0;
    req_halt = 1'b1;
    tick(5);
    `CHK("marking_end", 1'b0, mark)
    `CHK("emission_therm", 1'b1, emis)
    `CHK("level_therm", therm_lvl, lvl)
    for (i = 0; i < 3000; i++) begin
      if (gate !== 1'b0) gz++;
      tick(1);
    end
    `CHK("gate_therm", 0, gz)
    req_halt = 1'b0;
    tick(4);
  endtask
  initial begin
    #(20 * 95000);
    failures++;
    wrap_up();
  end
  initial begin
    tick(4);
    rst_b_i = 1'b1;
    tick(1);
    `CHK("rst_gate", 1'b0, gate)
    `CHK("rst_emis", 1'b0, emis)
    `CHK("rst_trace", 1'b0, trace)
    // manual mode must ignore the controller
    auto_mode_i = 1'b0;
    req_begin = 1'b1;
    tick(8);
    `CHK("trace_on", 1'b1, trace)
    `CHK("manual_ignore", 1'b0, mark)
    req_begin = 1'b0;
    auto_mode_i = 1'b1;
    tick(8);
    `CHK("trace_off", 1'b0, trace)
    // random levels kept above the slew probe's reach
    mark_lvl = 8'($random(seed)) | 8'hc0;
    // thermalization a little below the marking level
    therm_lvl = mark_lvl - (8'($random(seed)) & 8'h0f);
    // shot time and suppression delay stay at their presets
    period = 16'(500 + {$random(seed)} % 2001);
    run_mark();
    halt_to_therm();
    // period below the legal range is clamped to the fastest rate
    period = 16'h0010;
    run_mark();
    // dropping to manual while marking must darken the source
    auto_mode_i = 1'b0;
    tick(8);
    `CHK("trace_abort", 1'b1, trace)
    `CHK("emis_abort", 1'b0, emis)
    `CHK("gate_abort", 1'b0, gate)
    wrap_up();
  end
endmodule
